/* File: core/hpc_params.svh */
// Register offsets, field positions, reset values and numeric constants
`ifndef HPC_PARAMS_SVH
`define HPC_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define HPC_OFF_STATUS   8'h00
`define HPC_OFF_IMASK    8'h04
`define HPC_OFF_SRC      8'h08
`define HPC_OFF_IMM      8'h0c
`define HPC_OFF_RESULT   8'h10
`define HPC_OFF_ECX      8'h14
`define HPC_OFF_STATE_EN 8'h18

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define HPC_CTRL_RST     8'h1f
`define HPC_CTRL_RC_LSB  5
`define HPC_CTRL_FTZ     7
`define HPC_IMASK_RST    5'h00
`define HPC_IMM_MS       2
`define HPC_RES_FAULT    16
`define HPC_RES_DONE     17
`define HPC_ECX_OSSAVE   27
`define HPC_ECX_VEXT     28
`define HPC_ECX_HCVT     29
`define HPC_STEN_RST     3'h1
`define HPC_STEN_WMASK   3'h6

// ----------------------------------------------------------------
// Numeric constants of the conversion
// ----------------------------------------------------------------
`define HPC_EXP_ADJ      8'h70
`define HPC_DEN_BASE     8'h7e
`define HPC_NORM_SH      5'h0d
`define HPC_MAX_SH       5'h1f
`define HPC_HEXP_MAX     5'h1f
`define HPC_SEXP_MAX     8'hff

`endif

/* File: core/hpc_pkg.sv */
// Types shared by the half precision conversion block
package hpc_pkg;

    typedef enum logic [1:0] {
        HPC_RNE,
        HPC_RDN,
        HPC_RUP,
        HPC_RTZ
    } hpc_rnd_type;

    typedef enum logic {
        HPC_BUS_IDLE,
        HPC_BUS_ACK
    } hpc_bus_type;

    // Bit 0 is invalid, bit 4 is precision
    typedef struct packed {
        logic pe;
        logic ue;
        logic oe;
        logic de;
        logic ie;
    } hpc_flags_type;

    typedef struct packed {
        logic [31:0] src;
        hpc_rnd_type rnd;
    } hpc_cvt_in_type;

    typedef struct packed {
        logic        sign;
        logic        nan;
        logic        snan;
        logic        src_den;
        logic        tiny;
        logic        ovf;
        logic        inexact;
        logic [15:0] half;
    } hpc_num_type;

endpackage

/* File: core/hpc_flag_cell.sv */
// One sticky exception flag, set by hardware and cleared by software
`timescale 1ns/1ns
module hpc_flag_cell #(
    parameter logic RST_VAL = 1'b0
) (
    // Clock, reset and enable
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic ce,
    // Set and clear
    input  wire logic set,
    input  wire logic clr,
    output logic      q
);
    logic d;

    // Set wins so an event in the clearing cycle is kept
    always_comb begin
        d = q;
        if (clr) begin
            d = 1'b0;
        end
        if (set) begin
            d = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            q <= RST_VAL;
        end else if (ce) begin
            q <= d;
        end
    end
endmodule

/* File: core/hpc_cvt.sv */
// Single to half precision rounding and classification datapath
`timescale 1ns/1ns
`include "hpc_params.svh"
module hpc_cvt (
    // Operand and rounding mode
    input  hpc_pkg::hpc_cvt_in_type cvt_in,
    // Classified and rounded value
    output hpc_pkg::hpc_num_type    num
);
    import hpc_pkg::*;

    logic        sign;
    logic [7:0]  exp;
    logic [22:0] frac;
    logic        is_norm;
    logic [8:0]  he;
    logic [7:0]  den_sh;
    logic [4:0]  sh;
    logic [55:0] ext;
    logic [10:0] kept;
    logic        guard;
    logic        sticky;
    logic        inc;
    logic [11:0] rnd;
    logic [8:0]  he_r;

    always_comb begin
        sign    = cvt_in.src[31];
        exp     = cvt_in.src[30:23];
        frac    = cvt_in.src[22:0];
        is_norm = exp > `HPC_EXP_ADJ;
        he      = {1'b0, exp} - {1'b0, `HPC_EXP_ADJ};
        den_sh  = `HPC_DEN_BASE - exp;
        // Tiny values shift right so the half denormal grid lines up
        if (is_norm) begin
            sh = `HPC_NORM_SH;
        end else if (exp == 8'h00 || den_sh > {3'h0, `HPC_MAX_SH}) begin
            sh = `HPC_MAX_SH;
        end else begin
            sh = den_sh[4:0];
        end
        // Pad wide enough that no set bit is shifted out of the sticky
        ext    = {exp != 8'h00, frac, 32'h00000000} >> sh;
        kept   = ext[42:32];
        guard  = ext[31];
        sticky = |ext[30:0];
        case (cvt_in.rnd)
            HPC_RNE: inc = guard & (sticky | kept[0]);
            HPC_RDN: inc = sign & (guard | sticky);
            HPC_RUP: inc = ~sign & (guard | sticky);
            default: inc = 1'b0;
        endcase
        rnd  = {1'b0, kept} + {11'h000, inc};
        he_r = he + {8'h00, rnd[11]};
        num.sign    = sign;
        num.nan     = (exp == `HPC_SEXP_MAX) && (frac != 23'h000000);
        num.snan    = num.nan && !frac[22];
        // Denormal source judged against the single format
        num.src_den = (exp == 8'h00) && (frac != 23'h000000);
        // Below the smallest half normal, flush control ignored
        num.tiny    = !is_norm
                      && (exp != 8'h00 || frac != 23'h000000);
        num.ovf     = is_norm && (exp != `HPC_SEXP_MAX)
                      && (he_r >= {4'h0, `HPC_HEXP_MAX});
        num.inexact = (exp != `HPC_SEXP_MAX) && (guard | sticky);
        if (exp == `HPC_SEXP_MAX) begin
            num.half = {sign, `HPC_HEXP_MAX, num.nan, frac[21:13]};
            if (num.nan) begin
                num.half[9] = 1'b1;
            end
        end else if (is_norm) begin
            num.half = {sign, he_r[4:0], rnd[9:0]};
        end else begin
            num.half = {sign, 4'h0, rnd[10], rnd[9:0]};
        end
    end
endmodule

/* File: core/hpc_top.sv */
// Half precision conversion unit with exceptions, on an Avalon-MM slave
//
// Functional notes
// - Underflow handling ignores flush-to-zero, acting as if it were clear.
// - Overflow is detected when the result magnitude reaches two to 16.
// - Overflow always sets its flag; masked, result is signed infinity.
// - Inexact is raised when the half result is not exact.
// - Precision masked: deliver rounded bounded result, set precision flag.
// - Precision unmasked: masked under/overflow result, else rounded.
// - Denormal source, mask mix: denormal, underflow, precision flags set.
// - Feature word bit 28 reports the wide vector extension.
// - Feature word bit 29 reports the half conversion instructions.
// - Underflow is detected below two to minus 14.
// - Rounding comes from immediate bits 1:0 or from rounding control.
`timescale 1ns/1ns
`include "hpc_params.svh"
module hpc_top (
    // Clock, reset and enable
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Interrupt
    output logic             irq
);
    import hpc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    hpc_bus_type    bus_q;
    hpc_bus_type    bus_d;
    logic           wait_q;
    logic           wait_d;
    logic [31:0]    rdata_q;
    logic [31:0]    rdata_d;
    logic [7:0]     ctrl_q;
    logic [7:0]     ctrl_d;
    logic [4:0]     imask_q;
    logic [4:0]     imask_d;
    logic [7:0]     imm_q;
    logic [7:0]     imm_d;
    logic [15:0]    half_q;
    logic [15:0]    half_d;
    logic           fault_q;
    logic           fault_d;
    logic           done_q;
    logic           done_d;
    logic [2:0]     sten_q;
    logic [2:0]     sten_d;
    logic           irq_q;
    logic           irq_d;
    logic [4:0]     flags_q;
    logic           req;
    logic           take;
    logic           wr_go;
    logic           rd_go;
    logic           conv_go;
    logic [4:0]     flag_set;
    logic [4:0]     flag_clr;
    logic [4:0]     xmask;
    hpc_cvt_in_type cvt_in;
    hpc_num_type    num;
    hpc_flags_type  raise;
    logic           fault;
    logic [15:0]    result;
    logic [31:0]    status_word;

    // ------------------------------------------------------------
    // Bus handshake
    // ------------------------------------------------------------
    // One wait state gives the read mux a full cycle
    always_comb begin
        req    = avs_read | avs_write;
        bus_d  = bus_q;
        wait_d = 1'b1;
        case (bus_q)
            HPC_BUS_IDLE: begin
                if (req) begin
                    bus_d  = HPC_BUS_ACK;
                    wait_d = 1'b0;
                end
            end
            HPC_BUS_ACK: begin
                bus_d = HPC_BUS_IDLE;
            end
            default: begin
                bus_d = HPC_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            bus_q  <= HPC_BUS_IDLE;
            wait_q <= 1'b1;
        end else if (ce) begin
            bus_q  <= bus_d;
            wait_q <= wait_d;
        end
    end

    always_comb begin
        take    = req && (bus_q == HPC_BUS_ACK);
        wr_go   = take && avs_write;
        rd_go   = take && avs_read;
        conv_go = wr_go && (avs_address == `HPC_OFF_SRC)
                  && (avs_byteenable == 4'hf);
    end

    // ------------------------------------------------------------
    // Conversion datapath and exception policy
    // ------------------------------------------------------------
    always_comb begin
        cvt_in.src = avs_writedata;
        // Immediate override or control register rounding
        if (imm_q[`HPC_IMM_MS]) begin
            cvt_in.rnd = hpc_rnd_type'(ctrl_q[`HPC_CTRL_RC_LSB +: 2]);
        end else begin
            cvt_in.rnd = hpc_rnd_type'(imm_q[1:0]);
        end
    end

    hpc_cvt u_cvt (
        .cvt_in (cvt_in),
        .num    (num)
    );

    always_comb begin
        xmask = ctrl_q[4:0];
        raise = '0;
        raise.ie = num.snan;
        raise.de = num.src_den;
        raise.oe = num.ovf;
        raise.ue = num.tiny;
        raise.pe = num.inexact | num.ovf;
        // Unmasked overflow reports alone
        if (num.ovf && !xmask[2]) begin
            raise.pe = 1'b0;
        end
        // Denormal source with mixed masks raises all three
        if (num.src_den && xmask[1] && (!xmask[4] || !xmask[3])) begin
            raise.de = 1'b1;
            raise.ue = 1'b1;
            raise.pe = 1'b1;
        end
        // Any unmasked flag faults; precision alone keeps the result
        fault = |(raise & ~xmask);
        if (num.nan) begin
            result = num.half;
        end else if (num.ovf) begin
            result = {num.sign, `HPC_HEXP_MAX, 10'h000};
        end else begin
            result = num.half;
        end
    end

    // ------------------------------------------------------------
    // Sticky exception flags
    // ------------------------------------------------------------
    always_comb begin
        flag_set = conv_go ? raise : 5'h00;
        flag_clr = 5'h00;
        if (wr_go && avs_address == `HPC_OFF_STATUS && avs_byteenable[0]) begin
            flag_clr = avs_writedata[4:0];
        end
    end

    for (genvar i = 0; i < 5; i++) begin : g_flag
        hpc_flag_cell #(
            .RST_VAL (1'b0)
        ) u_flag (
            .clock (clock),
            .rst_n (rst_n),
            .ce    (ce),
            .set   (flag_set[i]),
            .clr   (flag_clr[i]),
            .q     (flags_q[i])
        );
    end

    // ------------------------------------------------------------
    // Register writes and result capture
    // ------------------------------------------------------------
    always_comb begin
        ctrl_d  = ctrl_q;
        imask_d = imask_q;
        imm_d   = imm_q;
        half_d  = half_q;
        fault_d = fault_q;
        done_d  = done_q;
        sten_d  = sten_q;
        if (wr_go) begin
            case (avs_address)
                `HPC_OFF_STATUS: begin
                    if (avs_byteenable[1]) begin
                        ctrl_d = avs_writedata[15:8];
                    end
                end
                `HPC_OFF_IMASK: begin
                    if (avs_byteenable[0]) begin
                        imask_d = avs_writedata[4:0];
                    end
                end
                `HPC_OFF_IMM: begin
                    if (avs_byteenable[0]) begin
                        imm_d = avs_writedata[7:0];
                    end
                end
                `HPC_OFF_STATE_EN: begin
                    if (avs_byteenable[0]) begin
                        sten_d = (sten_q & ~`HPC_STEN_WMASK)
                                 | (avs_writedata[2:0] & `HPC_STEN_WMASK);
                    end
                end
                default: begin
                    sten_d = sten_q;
                end
            endcase
        end
        // Reading the result clears done; a new result wins
        if (rd_go && avs_address == `HPC_OFF_RESULT) begin
            done_d = 1'b0;
        end
        if (conv_go) begin
            done_d  = 1'b1;
            fault_d = fault;
            if (!(|(raise[3:0] & ~xmask[3:0]))) begin
                half_d = result;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            ctrl_q  <= `HPC_CTRL_RST;
            imask_q <= `HPC_IMASK_RST;
            imm_q   <= 8'h00;
            half_q  <= 16'h0000;
            fault_q <= 1'b0;
            done_q  <= 1'b0;
            sten_q  <= `HPC_STEN_RST;
        end else if (ce) begin
            ctrl_q  <= ctrl_d;
            imask_q <= imask_d;
            imm_q   <= imm_d;
            half_q  <= half_d;
            fault_q <= fault_d;
            done_q  <= done_d;
            sten_q  <= sten_d;
        end
    end

    // ------------------------------------------------------------
    // Read data and interrupt
    // ------------------------------------------------------------
    // Unmapped offsets read as zero
    always_comb begin
        status_word = {16'h0000, ctrl_q, 3'h0, flags_q};
        rdata_d     = rdata_q;
        if (req && bus_q == HPC_BUS_IDLE) begin
            case (avs_address)
                `HPC_OFF_STATUS:   rdata_d = status_word;
                `HPC_OFF_IMASK:    rdata_d = {27'h0000000, imask_q};
                `HPC_OFF_IMM:      rdata_d = {24'h000000, imm_q};
                `HPC_OFF_RESULT:   rdata_d = {14'h0000, done_q,
                                              fault_q, half_q};
                `HPC_OFF_ECX: begin
                    rdata_d = 32'h00000000;
                    rdata_d[`HPC_ECX_OSSAVE] = 1'b1;
                    rdata_d[`HPC_ECX_VEXT]   = 1'b1;
                    rdata_d[`HPC_ECX_HCVT]   = 1'b1;
                end
                `HPC_OFF_STATE_EN: rdata_d = {29'h00000000, sten_q};
                default:           rdata_d = 32'h00000000;
            endcase
        end
        irq_d = |(flags_q & imask_q);
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            rdata_q <= 32'h00000000;
            irq_q   <= 1'b0;
        end else if (ce) begin
            rdata_q <= rdata_d;
            irq_q   <= irq_d;
        end
    end

    always_comb begin
        avs_readdata    = rdata_q;
        avs_waitrequest = wait_q;
        irq             = irq_q;
    end
endmodule

/* File: verif/hpc_top_monitor.sv */
// Assertion checker for the conversion unit's bus and interrupt
`timescale 1ns/1ns
`include "hpc_params.svh"
module hpc_top_monitor (
    // Clock, reset and enable
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic        ce,
    // Avalon-MM slave
    input wire logic [7:0]  avs_address,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0]  avs_byteenable,
    input wire logic [31:0] avs_readdata,
    input wire logic        avs_waitrequest,
    // Interrupt
    input wire logic        irq
);
    // ------------------------------------------------------------
    // Pending flag causes, dropped only by their own clear bit
    // ------------------------------------------------------------
    logic [7:0] sexp;
    logic       ack_w;
    logic       ack_r;
    logic       clr_w;
    logic       cause_w;
    logic [2:0] pend_q;
    logic [2:0] pend_d;
    assign sexp  = avs_writedata[30:23];
    assign ack_w = avs_write && !avs_waitrequest && ce;
    assign ack_r = avs_read && !avs_waitrequest && ce;
    assign clr_w = ack_w && (avs_address == `HPC_OFF_STATUS ||
                             avs_address == `HPC_OFF_IMASK);
    assign cause_w = ack_w && (avs_address == `HPC_OFF_SRC ||
                               avs_address == `HPC_OFF_IMASK);
    always_comb begin
        pend_d = pend_q;
        if (ack_w && avs_address == `HPC_OFF_STATUS) begin
            pend_d = pend_q & ~avs_writedata[3:1];
        end
        if (ack_w && avs_address == `HPC_OFF_SRC && &avs_byteenable) begin
            pend_d[0] = pend_q[0] || (sexp == 8'h00 && |avs_writedata[22:0]);
            pend_d[1] = pend_q[1] || (sexp >= 8'h8f && sexp != 8'hff);
            pend_d[2] = pend_q[2] || (sexp <= 8'h70 && |avs_writedata[30:0]);
        end
    end
    always_ff @(posedge clock) begin
        pend_q <= !rst_n ? 3'h0 : (ce ? pend_d : pend_q);
    end
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    sequence s_start;
        (avs_read || avs_write) && avs_waitrequest && ce;
    endsequence
    sequence s_ack;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    sequence s_stat_rd;
        ack_r && avs_address == `HPC_OFF_STATUS;
    endsequence
    AST_ONE_WAIT: assert property (s_start |=> s_ack)
        else $error("access not answered after one wait state");
    AST_IDLE_WAIT: assert property (!avs_read && !avs_write |->
        avs_waitrequest) else $error("acknowledge without request");
    AST_UNMAPPED: assert property (ack_r && avs_address >= 8'h1c |->
        avs_readdata == 32'h0) else $error("unmapped read not zero");
    AST_VEXT_BIT: assert property (
        ack_r && avs_address == `HPC_OFF_ECX |->
        avs_readdata[`HPC_ECX_VEXT]) else $error("vector bit clear");
    AST_HCVT_BIT: assert property (
        ack_r && avs_address == `HPC_OFF_ECX |->
        avs_readdata[`HPC_ECX_HCVT]) else $error("convert bit clear");
    AST_OVF_FLAG: assert property (
        s_stat_rd and pend_q[1] |-> avs_readdata[2])
        else $error("overflow flag missing");
    AST_UDF_FLAG: assert property (
        s_stat_rd and pend_q[2] |-> avs_readdata[3])
        else $error("underflow flag missing");
    AST_DEN_FLAG: assert property (
        s_stat_rd and pend_q[0] |-> avs_readdata[1])
        else $error("denormal flag missing");
    AST_IRQ_HOLD: assert property (
        irq && !clr_w && !$past(clr_w) |=> irq)
        else $error("interrupt dropped without a clear");
    AST_IRQ_CAUSE: assert property ($rose(irq) |->
        $past(cause_w, 2)) else $error("interrupt without cause");
endmodule

bind hpc_top hpc_top_monitor u_mon (
    .clock(clock), .rst_n(rst_n), .ce(ce), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .irq(irq)
);

/* File: verif/hpc_sw_model.sv */
// Software side: issues register accesses and the feature check
`timescale 1ns/1ns
`include "hpc_params.svh"
module hpc_sw_model (
    // Clock
    input  wire logic        clock,
    // Avalon-MM master
    output logic      [7:0]  avs_address,
    output logic             avs_read,
    output logic             avs_write,
    output logic      [31:0] avs_writedata,
    output logic      [3:0]  avs_byteenable,
    input  wire logic [31:0] avs_readdata,
    input  wire logic        avs_waitrequest
);
    // ------------------------------------------------------------
    // Bus cycles, called just after a rising edge
    // ------------------------------------------------------------
    initial begin
        avs_address    = 8'h00;
        avs_read       = 1'b0;
        avs_write      = 1'b0;
        avs_writedata  = 32'h0;
        avs_byteenable = 4'hf;
    end
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        avs_read      <= !w;
        avs_write     <= w;
        avs_address   <= a;
        avs_writedata <= d;
        @(posedge clock);
        while (avs_waitrequest) @(posedge clock);
        q = avs_readdata;
    endtask
    // Released lines flip so stale values cannot pass for fresh ones
    task automatic idle;
        avs_read      <= 1'b0;
        avs_write     <= 1'b0;
        avs_address   <= ~avs_address;
        avs_writedata <= ~avs_writedata;
        @(posedge clock);
    endtask
    task automatic detect(output logic ok);
        logic [31:0] v;
        xfer(1'b0, `HPC_OFF_ECX, 32'h0, v);
        ok = (v & 32'h38000000) == 32'h38000000;
        xfer(1'b0, `HPC_OFF_STATE_EN, 32'h0, v);
        ok = ok && ((v & 32'h6) == 32'h6);
    endtask
endmodule

/* File: verif/test_hpc_top.sv */
// Self-checking bench for the half precision conversion unit
`timescale 1ns/1ns
`include "hpc_params.svh"
module test_hpc_top;
    import hpc_pkg::*;
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [3:0]  avs_byteenable;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        irq;
    int          bad_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    logic [7:0]  ctrl = 8'h1f;
    logic [31:0] q;
    logic        ok;

    always #2 clock = ~clock;

    hpc_top dut (
        .clock(clock), .rst_n(rst_n), .ce(1'b1), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .irq(irq)
    );
    hpc_sw_model sw (
        .clock(clock), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest)
    );
    // ------------------------------------------------------------
    // Checking and bus helpers
    // ------------------------------------------------------------
    task automatic close_out;
        $display("Checks %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        sw.xfer(1'b1, a, d, q);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m,
                       input logic [31:0] e);
        sw.xfer(1'b0, a, 32'h0, q);
        check(q & m, e);
    endtask
    // Fault expected whenever a raised flag has its mask clear
    task automatic cvt(input logic [31:0] s, input logic [2:0] im,
                       input logic [15:0] h, input logic [4:0] f,
                       input logic [15:0] hm = 16'hffff);
        wr(`HPC_OFF_STATUS, {16'h0, ctrl, 8'h1f});
        wr(`HPC_OFF_IMM, {29'h0, im});
        wr(`HPC_OFF_SRC, s);
        rdc(`HPC_OFF_RESULT, {14'h0, 2'h3, hm},
            {14'h0, 1'b1, |(f & ~ctrl[4:0]), h & hm});
        rdc(`HPC_OFF_STATUS, 32'h1f, {27'h0, f});
    endtask
    always @(posedge clock) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            bad_count++;
            close_out();
        end
    end
    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        rdc(`HPC_OFF_STATUS, 32'hffff, 32'h1f00);
        rdc(`HPC_OFF_IMASK, 32'hffffffff, 32'h0);
        rdc(`HPC_OFF_RESULT, 32'hffffffff, 32'h0);
        rdc(`HPC_OFF_STATE_EN, 32'hffffffff, 32'h1);
        rdc(8'h1c, 32'hffffffff, 32'h0);
        rdc(`HPC_OFF_ECX, 32'h10000000, 32'h10000000);
        rdc(`HPC_OFF_ECX, 32'h20000000, 32'h20000000);
        sw.detect(ok);
        check(ok, 0);
        wr(`HPC_OFF_STATE_EN, 32'h6);
        rdc(`HPC_OFF_STATE_EN, 32'hffffffff, 32'h7);
        sw.detect(ok);
        check(ok, 1);
        $display("Test registers done");
        cvt(32'h3f800000, 3'h0, 16'h3c00, 5'h00);
        cvt(32'h477fe000, 3'h0, 16'h7bff, 5'h00);
        cvt(32'h47800000, 3'h0, 16'h7c00, 5'h14);
        cvt(32'hc7800000, 3'h3, 16'hfc00, 5'h14);
        cvt(32'h3f800001, 3'h0, 16'h3c00, 5'h10);
        cvt(32'h3f800001, 3'h1, 16'h3c00, 5'h10);
        cvt(32'h3f800001, 3'h2, 16'h3c01, 5'h10);
        cvt(32'hbf800001, 3'h1, 16'hbc01, 5'h10);
        cvt(32'hbf800001, 3'h3, 16'hbc00, 5'h10);
        ctrl = 8'h5f;
        cvt(32'h3f800001, 3'h4, 16'h3c01, 5'h10);
        ctrl = 8'h9f;
        cvt(32'h38000000, 3'h0, 16'h0200, 5'h08);
        cvt(32'h38800000, 3'h0, 16'h0400, 5'h00);
        cvt(32'h00000001, 3'h0, 16'h0000, 5'h1a);
        cvt(32'h7f800001, 3'h0, 16'h7e00, 5'h01);
        cvt(32'h7fc00000, 3'h0, 16'h7e00, 5'h00);
        $display("Test masked conversions done");
        ctrl = 8'h0f;
        cvt(32'h3f800001, 3'h0, 16'h3c00, 5'h10);
        cvt(32'h00000001, 3'h0, 16'h0000, 5'h1a, 16'h0);
        ctrl = 8'h1b;
        cvt(32'h47800000, 3'h0, 16'h0000, 5'h04, 16'h0);
        $display("Test unmasked conversions done");
        ctrl = 8'h1f;
        wr(`HPC_OFF_IMASK, 32'h4);
        cvt(32'h47800000, 3'h0, 16'h7c00, 5'h14);
        wr(`HPC_OFF_SRC, 32'h38000000);
        rdc(`HPC_OFF_STATUS, 32'h1f, 32'h1c);
        check(irq, 1);
        rdc(`HPC_OFF_RESULT, 32'h20000, 32'h20000);
        rdc(`HPC_OFF_RESULT, 32'h20000, 32'h0);
        wr(`HPC_OFF_STATUS, 32'h1f04);
        rdc(`HPC_OFF_STATUS, 32'h1f, 32'h18);
        check(irq, 0);
        sw.idle();
        $display("Test sticky flags done");
        close_out();
    end
endmodule
